// ---- rtl/sfl_ctrl.sv ----
// Self-programming control, fuse and lock readback, and boot section decode behind an AXI4-Lite slave.
//
// Summary of operation
// - While the EEPROM write is busy, store-program operations are refused.
// - While the EEPROM write is busy, fuse and lock readback is refused.
// - Pointer 0x0001 with both bits set lets a load within three cycles read lock.
// - Readback and enable bits clear on completion, or both together once the four-cycle window expires.
// - With both bits clear, a load performs an ordinary program-memory read.
// - Lock byte bits 5..0 hold boot-high, boot-low, general pairs; 7..6 undefined.
// - Pointer 0x0000 readback returns the full low fuse byte.
// - Pointer 0x0003 readback returns the high fuse byte.
// - Pointer 0x0002 readback returns the extended fuse byte.
// - Programmed bits read zero, unprogrammed bits read one.
// - A flash write in progress finishes even when reset is asserted.
// - Erase, write and lock writes last between 3.7 ms and 4.5 ms.
// - With boot lock programmed, self-programming writes into the boot section are rejected.
// - Boot size code 11,10,01,00 gives 128,256,512,1024 words at top of flash.
// - Boot start is 0x1F80,0x1F00,0x1E00,0x1C00; application ends one word below.
// - Control register bits are IE, busy, reserved, re-enable, select, write, erase, enable.
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`include "sfl_map.svh"
`default_nettype none
module sfl_ctrl
  import sfl_pkg::*;
#(
  parameter int PROG_CYCLES = `SFL_PROG_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic eeprom_write_busy_flag,
  input wire logic [7:0] prog_mem_byte,
  output logic flash_write_active,
  output logic [12:0] flash_write_page_addr,
  output logic [12:0] boot_start_addr
);

  // Three-stage synchroniser for the EEPROM busy level.
  // Only the second stage reads the first, and a change counts once stages two and three agree.
  logic ee_s1_q, ee_s2_q, ee_s3_q, ee_busy_q;
  always_ff @(posedge aclk) begin
    ee_s1_q <= eeprom_write_busy_flag;
    ee_s2_q <= ee_s1_q;
    ee_s3_q <= ee_s2_q;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ee_busy_q <= 1'b0;
    end else if (ee_s2_q == ee_s3_q) begin
      ee_busy_q <= ee_s3_q;
    end
  end

  // Boot section bounds from the two size-select bits.
  // The section always ends at the top of flash; only its start moves with the code.
  function automatic sfl_boot_t boot_decode(input logic [1:0] sz);
    sfl_boot_t b;
    b.boot_start = `SFL_BOOT_START_00;
    b.boot_pages = 9'h010;
    case (sz)
      2'b11: begin
        b.boot_start = `SFL_BOOT_START_11;
        b.boot_pages = 9'h002;
      end
      2'b10: begin
        b.boot_start = `SFL_BOOT_START_10;
        b.boot_pages = 9'h004;
      end
      2'b01: begin
        b.boot_start = `SFL_BOOT_START_01;
        b.boot_pages = 9'h008;
      end
      default: begin
        b.boot_start = `SFL_BOOT_START_00;
        b.boot_pages = 9'h010;
      end
    endcase
    b.app_end = b.boot_start - 13'h0001;
    return b;
  endfunction

  // Software-visible registers and internal window, sequencer and write-target state.
  logic [7:0] csr_q;
  logic [15:0] ptr_q;
  sfl_fuses_t fuse_q;
  logic [7:0] rd_byte_q;
  logic [1:0] rd_stat_q;
  logic [2:0] win_q;
  sfl_state_t state_q;
  logic [22:0] prog_cnt_q;
  logic rejected_q;
  logic [12:0] wpage_q;
  logic [1:0] wkind_q;
  logic [5:0] lock_new_q;

  // Write channel handshake: address and data taken in either order.
  // A new write fires only after the previous response is taken, so one write is under way at most.
  logic aw_hold_q, w_hold_q;
  logic [31:0] awaddr_q, wdata_q;
  logic [3:0] wstrb_q;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_q <= 1'b0;
      end
      if (w_take) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  // Register write decode.
  wire wr_csr = wr_fire && awaddr_q == `SFL_REG_CSR && wstrb_q[0];
  wire wr_ptr = wr_fire && awaddr_q == `SFL_REG_PTR;
  wire wr_fuse = wr_fire && awaddr_q == `SFL_REG_FUSE;
  wire wr_op = wr_fire && awaddr_q == `SFL_REG_OP && wstrb_q[0];
  wire wr_ok = awaddr_q == `SFL_REG_CSR || awaddr_q == `SFL_REG_PTR || awaddr_q == `SFL_REG_FUSE
    || awaddr_q == `SFL_REG_OP || awaddr_q == `SFL_REG_STAT;
  wire op_lpm = wr_op && wdata_q[`SFL_OP_LPM];
  wire op_spm = wr_op && wdata_q[`SFL_OP_SPM];

  // Armed-request qualification.
  // The window counter starts at the arming write, so a load must fire before count three
  // and a store before count four; the bits clear once the counter reaches four.
  wire armed = state_q == SFL_ARMED;
  wire rb_armed = armed && csr_q[`SFL_BIT_RBSEL];
  wire lpm_in_win = win_q < 3'(`SFL_LPM_WINDOW);
  wire spm_in_win = win_q < 3'(`SFL_SPM_WINDOW);
  wire rb_go = rb_armed && op_lpm && lpm_in_win && !ee_busy_q;
  wire spm_go = armed && op_spm && spm_in_win && !ee_busy_q;
  wire is_page_op = csr_q[`SFL_BIT_PAGE_WRITE] || csr_q[`SFL_BIT_PAGE_ERASE];
  wire is_lock_op = csr_q[`SFL_BIT_RBSEL];
  sfl_boot_t boot_w;
  assign boot_w = boot_decode({fuse_q.fuse_high[2], fuse_q.fuse_high[1]});
  wire [12:0] z_page = ptr_q[13:1];
  wire boot_locked = fuse_q.lock[4] == 1'b0 || fuse_q.lock[5] == 1'b0;
  wire into_boot = z_page >= boot_w.boot_start;
  wire reject_boot = spm_go && is_page_op && into_boot && boot_locked;
  wire start_prog = spm_go && (is_page_op || is_lock_op) && !reject_boot;
  wire win_expired = armed && !spm_in_win;
  wire prog_done = state_q == SFL_BUSY && prog_cnt_q == 23'(PROG_CYCLES - 1);
  wire arm_csr = wr_csr && wdata_q[`SFL_BIT_EN] && state_q == SFL_IDLE;

  // Readback byte selection; programmed bits already read as zero.
  logic [7:0] rb_byte;
  logic [1:0] rb_kind;
  assign rb_kind = ptr_q == `SFL_SEL_LOCK ? 2'd1 : ptr_q == `SFL_SEL_FUSE_LOW ? 2'd1 :
    ptr_q == `SFL_SEL_FUSE_HIGH ? 2'd1 : ptr_q == `SFL_SEL_FUSE_EXT ? 2'd1 : 2'd2;
  assign rb_byte = ptr_q == `SFL_SEL_LOCK ? {2'b11, fuse_q.lock} :
    ptr_q == `SFL_SEL_FUSE_LOW ? fuse_q.fuse_low :
    ptr_q == `SFL_SEL_FUSE_HIGH ? fuse_q.fuse_high :
    ptr_q == `SFL_SEL_FUSE_EXT ? fuse_q.fuse_ext :
    `SFL_UNDEF_BYTE;

  // Control register, pointer, readback result and window counter; the flash write is not aborted by reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      csr_q <= `SFL_CSR_RESET;
      ptr_q <= 16'h0000;
      rd_byte_q <= 8'h00;
      rd_stat_q <= 2'd0;
      win_q <= 3'h0;
      rejected_q <= 1'b0;
    end else begin
      if (wr_ptr) begin
        ptr_q <= wdata_q[15:0];
      end
      if (arm_csr) begin
        csr_q <= {wdata_q[7], csr_q[6], 1'b0, wdata_q[4:0]};
        win_q <= 3'h0;
      end else if (rb_go || spm_go || win_expired) begin
        csr_q[4:0] <= 5'h00;
      end else if (armed) begin
        win_q <= win_q + 3'h1;
      end else if (wr_csr && state_q == SFL_IDLE) begin
        csr_q[7] <= wdata_q[7];
      end
      // Writing the re-enable bit while idle clears the section-busy flag; a starting page operation sets it.
      if (wr_csr && wdata_q[`SFL_BIT_SECT_REEN] && state_q == SFL_IDLE) begin
        csr_q[`SFL_BIT_SECT_BUSY] <= 1'b0;
      end
      if (start_prog && is_page_op) begin
        csr_q[`SFL_BIT_SECT_BUSY] <= 1'b1;
      end
      if (rb_go) begin
        rd_byte_q <= rb_byte;
        rd_stat_q <= rb_kind;
      end else if (op_lpm) begin
        rd_byte_q <= prog_mem_byte;
        rd_stat_q <= 2'd0;
      end
      if (reject_boot) begin
        rejected_q <= 1'b1;
      end else if (start_prog) begin
        rejected_q <= 1'b0;
      end
    end
  end

  // Flash sequencer and latched write target, kept running through reset while a flash write is busy.
  always_ff @(posedge aclk) begin
    if (!aresetn && state_q != SFL_BUSY) begin
      state_q <= SFL_IDLE;
      prog_cnt_q <= 23'h000000;
      wpage_q <= 13'h0000;
      wkind_q <= 2'd0;
      lock_new_q <= 6'h3f;
    end else begin
      case (state_q)
        SFL_IDLE: begin
          if (arm_csr) begin
            state_q <= SFL_ARMED;
          end
        end
        SFL_ARMED: begin
          if (start_prog) begin
            state_q <= SFL_BUSY;
            prog_cnt_q <= 23'h000000;
            wpage_q <= z_page;
            wkind_q <= is_lock_op ? 2'd2 : 2'd1;
            lock_new_q <= wdata_q[13:8];
          end else if (rb_go || spm_go || win_expired) begin
            state_q <= SFL_IDLE;
          end
        end
        SFL_BUSY: begin
          prog_cnt_q <= prog_cnt_q + 23'h000001;
          if (prog_done) begin
            state_q <= SFL_IDLE;
          end
        end
        default: begin
          state_q <= SFL_IDLE;
        end
      endcase
    end
  end

  // Fuse and lock cells: loaded whole by software, lock bits included; a lock write only programs lock bits to zero.
  // A lock write only clears bits, so a programmed lock is never undone by a store.
  always_ff @(posedge aclk) begin
    if (!aresetn && state_q != SFL_BUSY) begin
      fuse_q <= '1;
    end else if (prog_done && wkind_q == 2'd2) begin
      fuse_q.lock <= fuse_q.lock & lock_new_q;
    end else if (wr_fuse && aresetn) begin
      fuse_q <= {wdata_q[7:0], wdata_q[15:8], wdata_q[23:16], wdata_q[29:24]};
    end
  end

  // Write response and read channel.
  // Read data is captured at the address handshake, so it stands unchanged while rready is low.
  logic [31:0] rdata_d;
  wire rd_take = s_axi_arvalid && s_axi_arready;
  assign rdata_d = s_axi_araddr == `SFL_REG_CSR ? {24'h000000, csr_q} :
    s_axi_araddr == `SFL_REG_PTR ? {16'h0000, ptr_q} :
    s_axi_araddr == `SFL_REG_FUSE ? {2'b00, fuse_q.lock, fuse_q.fuse_ext, fuse_q.fuse_high, fuse_q.fuse_low} :
    s_axi_araddr == `SFL_REG_STAT ? {19'h00000, state_q == SFL_BUSY, ee_busy_q, rejected_q, rd_stat_q, rd_byte_q} :
    32'h0000_0000;
  wire rd_ok = s_axi_araddr == `SFL_REG_CSR || s_axi_araddr == `SFL_REG_PTR ||
    s_axi_araddr == `SFL_REG_FUSE || s_axi_araddr == `SFL_REG_STAT || s_axi_araddr == `SFL_REG_OP;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_awready <= !aw_hold_q && !aw_take;
      s_axi_wready <= !w_hold_q && !w_take;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !rd_take;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_d;
        s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Flash-side outputs.
  // The page address follows the latched write target, and the boot start follows the size fuses.
  always_ff @(posedge aclk) begin
    if (!aresetn && state_q != SFL_BUSY) begin
      flash_write_active <= 1'b0;
      flash_write_page_addr <= 13'h0000;
      boot_start_addr <= `SFL_BOOT_START_11;
    end else begin
      flash_write_active <= state_q == SFL_BUSY && !prog_done;
      flash_write_page_addr <= wpage_q;
      boot_start_addr <= boot_w.boot_start;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/sfl_map.svh ----
// Offsets, field positions, reset values and timing counts of the self-programming readback block.
`ifndef SFL_MAP_SVH
`define SFL_MAP_SVH
`define SFL_CLK_HZ 20000000
`define SFL_PROG_MIN_US 3700
`define SFL_PROG_MAX_US 4500
`define SFL_PROG_CYCLES ((`SFL_PROG_MIN_US * (`SFL_CLK_HZ / 1000000) + `SFL_PROG_MAX_US * (`SFL_CLK_HZ / 1000000)) / 2)
`define SFL_LPM_WINDOW 3
`define SFL_SPM_WINDOW 4
`define SFL_SEL_FUSE_LOW 16'h0000
`define SFL_SEL_LOCK 16'h0001
`define SFL_SEL_FUSE_EXT 16'h0002
`define SFL_SEL_FUSE_HIGH 16'h0003
`define SFL_BOOT_START_11 13'h1f80
`define SFL_BOOT_START_10 13'h1f00
`define SFL_BOOT_START_01 13'h1e00
`define SFL_BOOT_START_00 13'h1c00
`define SFL_BIT_IE 7
`define SFL_BIT_SECT_BUSY 6
`define SFL_BIT_SECT_REEN 4
`define SFL_BIT_RBSEL 3
`define SFL_BIT_PAGE_WRITE 2
`define SFL_BIT_PAGE_ERASE 1
`define SFL_BIT_EN 0
`define SFL_CSR_RESET 8'h00
`define SFL_UNDEF_BYTE 8'hff
`define SFL_REG_CSR 32'h0000_0000
`define SFL_REG_PTR 32'h0000_0004
`define SFL_REG_FUSE 32'h0000_0008
`define SFL_REG_STAT 32'h0000_000c
`define SFL_REG_OP 32'h0000_0010
`define SFL_OP_LPM 0
`define SFL_OP_SPM 1
`endif

// ---- rtl/sfl_pkg.sv ----
// Types shared by the self-programming readback block.
package sfl_pkg;
  typedef enum logic [1:0] {
    SFL_IDLE,
    SFL_ARMED,
    SFL_BUSY
  } sfl_state_t;
  typedef struct packed {
    logic [7:0] fuse_low;
    logic [7:0] fuse_high;
    logic [7:0] fuse_ext;
    logic [5:0] lock;
  } sfl_fuses_t;
  typedef struct packed {
    logic [12:0] boot_start;
    logic [12:0] app_end;
    logic [8:0] boot_pages;
  } sfl_boot_t;
endpackage

// ---- verification/sfl_ctrl_tb.sv ----
// Self-checking bench for the self-programming readback block.
`timescale 1ns/1ns
`default_nettype none
module sfl_ctrl_tb;
  localparam int PC = 20;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, ee_go;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic eeprom_write_busy_flag, flash_write_active;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d, r;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] prog_mem_byte;
  logic [12:0] flash_write_page_addr, boot_start_addr;
  logic [7:0] ex [4] = '{8'h62, 8'hed, 8'hf1, 8'hdf};
  logic [12:0] bs [4] = '{13'h1c00, 13'h1e00, 13'h1f00, 13'h1f80};
  int fail_count = 0;
  int comparisons = 0;
  int k, n;
  sfl_ctrl #(.PROG_CYCLES(PC)) dut_u (.*);
  sfl_mem_model mem_u (.*);
  // Free-running system clock.
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge aclk);
  endtask
  task automatic lost(input int i);
    if (i >= 60) begin
      fail_count++;
      conclude();
    end
  endtask
  // Write one register, its response code into r; a low bready is raised once bvalid is seen.
  task automatic wr(input logic [31:0] a, v);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 60; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    r = {30'h0, s_axi_bresp};
    lost(i);
  endtask
  // Read one register into d, its response code into r; a low rready is raised once rvalid is seen.
  task automatic rd(input logic [31:0] a);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 60; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    d = s_axi_rdata;
    r = {30'h0, s_axi_rresp};
    lost(i);
  endtask
  // Arms a readback at pointer p, issues a load, and fetches the status word.
  task automatic load(input logic [31:0] p);
    wr(32'h4, p);
    wr(32'h0, 32'h9);
    wr(32'h10, 32'h1);
    rd(32'hc);
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, ee_go, aresetn} = '0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    s_axi_awaddr = '0;
    s_axi_wdata = '0;
    s_axi_araddr = '0;
    s_axi_wstrb = 4'hf;
    cyc(2);
    aresetn <= 1'b1;
    cyc(2);
    rd(32'h0);
    chk("csr reset", 32'h0, d);
    rd(32'h8);
    chk("fuse reset", 32'h3fffffff, d & 32'h3fffffff);
    s_axi_rready <= 1'b0;
    rd(32'h40);
    chk("unmapped resp", 32'h2, r);
    chk("unmapped data", 32'h0, d);
    s_axi_bready <= 1'b0;
    wr(32'h40, 32'h0);
    chk("unmapped write resp", 32'h2, r);
    $display("test reset values done");
    for (k = 0; k < 4; k++) begin
      wr(32'h8, {2'b11, 6'h2d, 8'hf1, 8'(8'hd9 | (k << 1)), 8'h62});
      cyc(2);
      chk("boot start", {19'h0, bs[k]}, {19'h0, boot_start_addr});
    end
    $display("test boot decode done");
    for (k = 0; k < 4; k++) begin
      load(k);
      chk("readback", {22'h0, 2'b01, ex[k]}, d & 32'h3ff);
      rd(32'h0);
      chk("csr after read", 32'h0, d & 32'h9);
    end
    $display("test readback done");
    wr(32'h0, 32'h9);
    cyc(8);
    rd(32'h0);
    chk("csr expiry", 32'h0, d & 32'h9);
    wr(32'h10, 32'h1);
    rd(32'hc);
    chk("plain load", 32'h5a, d & 32'h3ff);
    load(32'h7);
    chk("odd pointer", 32'h2ff, d & 32'h3ff);
    rd(32'h8);
    chk("fuses kept", 32'h2df1df62, d & 32'h3fffffff);
    $display("test expiry done");
    ee_go <= 1'b1;
    cyc(1);
    ee_go <= 1'b0;
    cyc(6);
    load(32'h0);
    chk("ee busy seen", 32'h1, {31'h0, d[11]});
    chk("ee refused", 32'h0, {31'h0, d[9:8] == 2'b01});
    wr(32'h0, 32'h9);
    wr(32'h10, 32'h0f02);
    cyc(2);
    chk("ee store", 32'h0, {31'h0, flash_write_active});
    cyc(6);
    rd(32'h0);
    chk("ee armed cleared", 32'h0, d & 32'h9);
    for (k = 0; k < 40; k++) begin
      rd(32'hc);
      if (d[11] === 1'b0) break;
    end
    chk("ee clear", 32'h0, {31'h0, d[11]});
    $display("test eeprom done");
    wr(32'h4, 32'h1);
    wr(32'h0, 32'h9);
    wr(32'h10, 32'h0f02);
    for (k = 0; k < 10 && !flash_write_active; k++) cyc(1);
    for (n = 0; n < 60 && flash_write_active; n++) begin
      aresetn <= (n < 4 || n > 5);
      cyc(1);
    end
    chk("write length", 32'h1, {31'h0, n >= PC - 3 && n <= PC + 3});
    aresetn <= 1'b1;
    cyc(2);
    rd(32'h8);
    chk("lock after reset", 32'h0df1df62, d & 32'h3fffffff);
    wr(32'h8, 32'h0fdaf162);
    wr(32'h4, 32'h3c00);
    wr(32'h0, 32'h5);
    wr(32'h10, 32'h2);
    rd(32'hc);
    chk("boot reject", 32'h1, {31'h0, d[10]});
    wr(32'h4, 32'h0100);
    wr(32'h0, 32'h5);
    wr(32'h10, 32'h2);
    cyc(2);
    chk("app page", 32'h80, {19'h0, flash_write_page_addr});
    rd(32'h0);
    chk("section busy", 32'h40, d & 32'h40);
    $display("test flash write done");
    conclude();
  end
endmodule
bind sfl_ctrl sfl_props #(.PROG_CYCLES(PROG_CYCLES)) props_u (.*);
`default_nettype wire

// ---- verification/sfl_mem_model.sv ----
// Far-side model: program memory byte source and eeprom write busy flag.
`timescale 1ns/1ns
`default_nettype none
module sfl_mem_model #(
  parameter logic [7:0] DATA = 8'h5a,
  parameter int EE_CYCLES = 40
) (
  input wire logic aclk,
  input wire logic ee_go,
  output logic eeprom_write_busy_flag,
  output logic [7:0] prog_mem_byte
);
  int left_q = 0;
  // An eeprom write holds the busy flag for a fixed number of cycles.
  always_ff @(posedge aclk) begin
    left_q <= ee_go ? EE_CYCLES : (left_q > 0 ? left_q - 1 : 0);
  end
  assign eeprom_write_busy_flag = left_q > 0;
  assign prog_mem_byte = DATA;
endmodule
`default_nettype wire

// ---- verification/sfl_props.sv ----
// Concurrent checks on the ports of the self-programming readback block.
`timescale 1ns/1ns
`default_nettype none
module sfl_props #(
  parameter int PROG_CYCLES = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic eeprom_write_busy_flag,
  input wire logic flash_write_active,
  input wire logic [12:0] boot_start_addr
);
  int cnt_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Counts the cycles of a flash write; not cleared by reset, since the write outlives it.
  always_ff @(posedge aclk) begin
    cnt_q <= flash_write_active ? cnt_q + 1 : 0;
  end
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence far_read;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr > 32'h10);
  endsequence
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response changed early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (both_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_far_refused: assert property (far_read |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_ee_blocks: assert property (eeprom_write_busy_flag [*8] |=> !$rose(flash_write_active))
    else $error("flash write began during eeprom write");
  a_write_length: assert property ($fell(flash_write_active) |-> cnt_q inside {[PROG_CYCLES - 2:PROG_CYCLES + 2]})
    else $error("flash write length wrong");
  a_boot_start: assert property (boot_start_addr inside {13'h1f80, 13'h1f00, 13'h1e00, 13'h1c00})
    else $error("boot start not a legal value");
endmodule
`default_nettype wire
